// ===== core/vfdc_params.svh
// constants for the serial command receiver
`ifndef VFDC_PARAMS_SVH
`define VFDC_PARAMS_SVH

// word framing
`define VFDC_WORD_BITS 8
`define VFDC_BIT_CNT_W 3
`define VFDC_LAST_BIT 3'h7

// command byte fields
`define VFDC_CMD_MARK_BIT 7
`define VFDC_OP_MSB 6
`define VFDC_OP_LSB 4

// parameter byte fields
`define VFDC_NIB_MSB 3
`define VFDC_CHAR_MSB 6
`define VFDC_CURSOR_BIT 7
`define VFDC_LAMP_BIT 0

// reset values
`define VFDC_DUTY_RST 4'h0
`define VFDC_DIGITS_RST 4'h0
`define VFDC_ADDR_RST 4'h0
`define VFDC_LAMP_RST 1'b0
`define VFDC_CHAR_RST 7'h00
`define VFDC_ALL_DIGITS 5'h10

`endif

// ===== core/vfdc_pkg.sv
// types shared by the serial command receiver
package vfdc_pkg;

  // framing state of the byte decoder
  typedef enum logic [1:0] {
    VFDC_ST_CMD    = 2'b00,
    VFDC_ST_PARAM  = 2'b01,
    VFDC_ST_STREAM = 2'b10
  } vfdc_state_t;

  // command select field of the command byte
  typedef enum logic [2:0] {
    VFDC_OP_ADDR   = 3'b000,
    VFDC_OP_CHAR   = 3'b001,
    VFDC_OP_DUTY   = 3'b010,
    VFDC_OP_DIGITS = 3'b011,
    VFDC_OP_LAMP   = 3'b100
  } vfdc_op_t;

endpackage

// ===== core/vfdc_serial_cmd.sv
// serial command receiver, decoder and display ram for the display controller
// Function
// - serial bits are taken only while the active-low chip select is low.
// - words are eight bits, sent and assembled least significant bit first.
// - data input is sampled and shifted on the shift clock rising edge.
// - after eight bits an internal load strobe writes the byte to its target.
// - chip select rising stops transfer; falling restarts framing in fresh eight-bit groups.
// - first byte after select is the command, the second its parameter.
// - command byte has bit 7 set; bits 6..4 pick the command, 3..0 ignored.
// - character command stores bits 6..0 as code, bit 7 as cursor flag.
// - after a character command, later bytes before select rises are character data; address increments after each.
// - digit count register is four bits; zero means all sixteen digits.
// - lamp test lights every segment without touching display ram.
`timescale 1ns/10ps
`include "vfdc_params.svh"

module vfdc_serial_cmd #(
  parameter int NUM_DIGITS = 16
) (
  // system clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // serial host pins
  input wire logic shift_clock_n,
  input wire logic cs_n,
  input wire logic serial_data_in,
  // display ram read port for the scan logic
  input wire logic [3:0] rd_addr,
  output logic [6:0] rd_char_code,
  output logic rd_cursor_flag,
  // control outputs
  output logic [3:0] duty_value,
  output logic [3:0] digit_count,
  output logic [4:0] active_digits,
  output logic lamp_test_bit,
  output logic load_strobe
);

  localparam int AW = 4;

  // the address field is four bits, so sixteen digits is the only fit
  if (NUM_DIGITS != 16) begin : g_bad_digits
    $error("vfdc_serial_cmd: NUM_DIGITS must be 16");
  end

  // ---------------- link domain, clocked by the shift clock ----------------

  // framing is held in reset whenever select is high or the chip is reset
  logic link_rst_n;
  assign link_rst_n = arst_n & ~cs_n;

  logic [7:0] shreg_q;
  logic [7:0] shreg_d;
  logic [`VFDC_BIT_CNT_W-1:0] bitcnt_q;
  logic [`VFDC_BIT_CNT_W-1:0] bitcnt_d;
  logic [7:0] byte_q;
  logic [7:0] byte_d;
  logic tog_q;
  logic tog_d;

  // shift right so the first bit ends up in bit 0
  always_comb begin
    shreg_d = {serial_data_in, shreg_q[7:1]};
    bitcnt_d = bitcnt_q + 3'h1;
    byte_d = byte_q;
    tog_d = tog_q;
    if (bitcnt_q == `VFDC_LAST_BIT) begin
      byte_d = {serial_data_in, shreg_q[7:1]};
      tog_d = ~tog_q;
      bitcnt_d = 3'h0;
    end
  end

  // bit counter and shifter drop a partial byte when select rises
  always_ff @(posedge shift_clock_n or negedge link_rst_n) begin
    if (!link_rst_n) begin
      shreg_q <= 8'h00;
      bitcnt_q <= 3'h0;
    end else begin
      shreg_q <= shreg_d;
      bitcnt_q <= bitcnt_d;
    end
  end

  // completed byte and its event toggle survive the end of a frame
  always_ff @(posedge shift_clock_n or negedge arst_n) begin
    if (!arst_n) begin
      byte_q <= 8'h00;
      tog_q <= 1'b0;
    end else begin
      byte_q <= byte_d;
      tog_q <= tog_d;
    end
  end

  // ---------------- system domain ----------------

  // three-stage synchronisers for the byte toggle and chip select
  logic [2:0] tog_s_q;
  logic [2:0] tog_s_d;
  logic [2:0] cs_s_q;
  logic [2:0] cs_s_d;
  logic cs_hi_q;
  logic cs_hi_d;
  logic byte_evt;

  always_comb begin
    tog_s_d = {tog_s_q[1:0], tog_q};
    cs_s_d = {cs_s_q[1:0], cs_n};
    cs_hi_d = cs_hi_q;
    if (cs_s_q[1] == cs_s_q[2]) begin
      cs_hi_d = cs_s_q[2];
    end
  end

  // a new byte is seen while the two late stages differ
  assign byte_evt = tog_s_q[1] ^ tog_s_q[2];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tog_s_q <= 3'h0;
      cs_s_q <= 3'h7;
      cs_hi_q <= 1'b1;
    end else begin
      tog_s_q <= tog_s_d;
      cs_s_q <= cs_s_d;
      cs_hi_q <= cs_hi_d;
    end
  end

  // decoder state and the registers it loads
  vfdc_pkg::vfdc_state_t st_q;
  vfdc_pkg::vfdc_state_t st_d;
  vfdc_pkg::vfdc_op_t op_q;
  vfdc_pkg::vfdc_op_t op_d;
  logic [AW-1:0] addr_q;
  logic [AW-1:0] addr_d;
  logic [3:0] duty_q;
  logic [3:0] duty_d;
  logic [3:0] digits_q;
  logic [3:0] digits_d;
  logic lamp_q;
  logic lamp_d;
  logic wr_en;
  logic load_q;
  logic load_d;
  logic [2:0] cmd_op;

  assign cmd_op = byte_q[`VFDC_OP_MSB:`VFDC_OP_LSB];

  // byte framing and command decode
  always_comb begin
    st_d = st_q;
    op_d = op_q;
    addr_d = addr_q;
    duty_d = duty_q;
    digits_d = digits_q;
    lamp_d = lamp_q;
    wr_en = 1'b0;
    load_d = 1'b0;
    if (cs_hi_q) begin
      st_d = vfdc_pkg::VFDC_ST_CMD;
    end else if (byte_evt) begin
      load_d = 1'b1;
      case (st_q)
        vfdc_pkg::VFDC_ST_CMD: begin
          // an unmarked or unknown command byte is ignored
          if (byte_q[`VFDC_CMD_MARK_BIT] && cmd_op <= 3'h4) begin
            op_d = vfdc_pkg::vfdc_op_t'(cmd_op);
            st_d = vfdc_pkg::VFDC_ST_PARAM;
          end
        end
        vfdc_pkg::VFDC_ST_PARAM: begin
          st_d = vfdc_pkg::VFDC_ST_CMD;
          case (op_q)
            vfdc_pkg::VFDC_OP_ADDR: begin
              addr_d = byte_q[`VFDC_NIB_MSB:0];
            end
            vfdc_pkg::VFDC_OP_CHAR: begin
              wr_en = 1'b1;
              addr_d = addr_q + 4'h1;
              st_d = vfdc_pkg::VFDC_ST_STREAM;
            end
            vfdc_pkg::VFDC_OP_DUTY: begin
              duty_d = byte_q[`VFDC_NIB_MSB:0];
            end
            vfdc_pkg::VFDC_OP_DIGITS: begin
              digits_d = byte_q[`VFDC_NIB_MSB:0];
            end
            vfdc_pkg::VFDC_OP_LAMP: begin
              lamp_d = byte_q[`VFDC_LAMP_BIT];
            end
            default: begin
              st_d = vfdc_pkg::VFDC_ST_CMD;
            end
          endcase
        end
        vfdc_pkg::VFDC_ST_STREAM: begin
          wr_en = 1'b1;
          addr_d = addr_q + 4'h1;
        end
        default: begin
          st_d = vfdc_pkg::VFDC_ST_CMD;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= vfdc_pkg::VFDC_ST_CMD;
      op_q <= vfdc_pkg::VFDC_OP_ADDR;
      addr_q <= `VFDC_ADDR_RST;
      duty_q <= `VFDC_DUTY_RST;
      digits_q <= `VFDC_DIGITS_RST;
      lamp_q <= `VFDC_LAMP_RST;
      load_q <= 1'b0;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      addr_q <= addr_d;
      duty_q <= duty_d;
      digits_q <= digits_d;
      lamp_q <= lamp_d;
      load_q <= load_d;
    end
  end

  // display ram: character code plus cursor per digit
  logic [6:0] ram_code [NUM_DIGITS];
  logic ram_cur [NUM_DIGITS];
  logic [6:0] rd_code_q;
  logic [6:0] rd_code_d;
  logic rd_cur_q;
  logic rd_cur_d;
  logic [4:0] act_q;
  logic [4:0] act_d;

  // read port; lamp test never reaches the ram contents
  always_comb begin
    rd_code_d = ram_code[rd_addr];
    rd_cur_d = ram_cur[rd_addr];
    act_d = (digits_q == 4'h0) ? `VFDC_ALL_DIGITS : {1'b0, digits_q};
  end

  // ram write on the load strobe of a character byte
  always_ff @(posedge clk) begin
    if (wr_en) begin
      ram_code[addr_q] <= byte_q[`VFDC_CHAR_MSB:0];
      ram_cur[addr_q] <= byte_q[`VFDC_CURSOR_BIT];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_code_q <= `VFDC_CHAR_RST;
      rd_cur_q <= 1'b0;
      act_q <= `VFDC_ALL_DIGITS;
    end else begin
      rd_code_q <= rd_code_d;
      rd_cur_q <= rd_cur_d;
      act_q <= act_d;
    end
  end

  // outputs straight from flip-flops
  assign rd_char_code = rd_code_q;
  assign rd_cursor_flag = rd_cur_q;
  assign duty_value = duty_q;
  assign digit_count = digits_q;
  assign active_digits = act_q;
  assign lamp_test_bit = lamp_q;
  assign load_strobe = load_q;

endmodule

// ===== tb/vfdc_host_model.sv
// host side model driving chip select, shift clock and serial data
`timescale 1ns/10ps
module vfdc_host_model (
  // serial host pins
  output logic shift_clock_n,
  output logic cs_n,
  output logic serial_data_in
);
  // idle levels, clock stands high outside frames
  initial begin
    shift_clock_n = 1'b1;
    cs_n = 1'b1;
    serial_data_in = 1'b0;
  end
  // 80 ns shift period, data steady around the rising edge
  task automatic put_bits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      shift_clock_n = 1'b0;
      serial_data_in = b[i];
      #40;
      shift_clock_n = 1'b1;
      #20;
      serial_data_in = ~b[i]; // hold over, line no longer valid
      #20;
    end
  endtask
  // select low well before the first shift edge
  task automatic frame_start();
    #13;
    cs_n = 1'b0;
    #500;
  endtask
  // release select, then keep it high long enough
  task automatic frame_end();
    #500;
    cs_n = 1'b1;
    #800;
  endtask
endmodule

// ===== tb/vfdc_serial_cmd_assertions.sv
// port checks for the serial command receiver
`timescale 1ns/10ps
module vfdc_serial_cmd_assertions #(
  parameter int NUM_DIGITS = 16
) (
  // clock, reset and watched ports
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cs_n,
  input wire logic [3:0] duty_value,
  input wire logic [3:0] digit_count,
  input wire logic [4:0] active_digits,
  input wire logic lamp_test_bit,
  input wire logic load_strobe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // select held high for a while
  sequence s_cs_idle;
    cs_n [*8];
  endsequence
  property p_pulse;
    load_strobe |=> !load_strobe;
  endproperty
  a_pulse: assert property (p_pulse) else $error("load strobe too long");
  property p_idle;
    s_cs_idle |-> !load_strobe;
  endproperty
  a_idle: assert property (p_idle) else $error("load while deselected");
  property p_map;
    1 |=> active_digits == (($past(digit_count) == 4'h0) ? 5'h10 : {1'b0, $past(digit_count)});
  endproperty
  a_map: assert property (p_map) else $error("digit count map wrong");
  property p_range;
    active_digits != 5'h00 && active_digits <= 5'h10;
  endproperty
  a_range: assert property (p_range) else $error("active digits out of range");
  property p_duty;
    $changed(duty_value) |-> load_strobe;
  endproperty
  a_duty: assert property (p_duty) else $error("duty changed without load");
  property p_digits;
    $changed(digit_count) |-> load_strobe;
  endproperty
  a_digits: assert property (p_digits) else $error("digit count changed without load");
  property p_lamp;
    $changed(lamp_test_bit) |-> load_strobe;
  endproperty
  a_lamp: assert property (p_lamp) else $error("lamp changed without load");
  property p_excl;
    $changed(duty_value) |-> $stable(digit_count) && $stable(lamp_test_bit);
  endproperty
  a_excl: assert property (p_excl) else $error("one byte wrote two registers");
endmodule
bind vfdc_serial_cmd vfdc_serial_cmd_assertions #(.NUM_DIGITS(NUM_DIGITS)) chk_u (.clk, .arst_n, .cs_n,
  .duty_value, .digit_count, .active_digits, .lamp_test_bit, .load_strobe);

// ===== tb/vfdc_serial_cmd_tb.sv
// self-checking bench for the serial command receiver
`timescale 1ns/10ps
module vfdc_serial_cmd_tb;
  logic clk, arst_n, sck_n, cs_n, sdi, lamp, ld, cur;
  logic [3:0] rd_addr, duty, digits;
  logic [6:0] code;
  logic [4:0] act;
  int num_errors, n_checks, cyc, seed, m_duty, m_dig, m_lamp, m_addr, m_st, m_op, n_loads, m_loads;
  int m_ram[16];
  vfdc_serial_cmd dut_u (.clk(clk), .arst_n(arst_n), .shift_clock_n(sck_n), .cs_n(cs_n),
    .serial_data_in(sdi), .rd_addr(rd_addr), .rd_char_code(code), .rd_cursor_flag(cur),
    .duty_value(duty), .digit_count(digits), .active_digits(act), .lamp_test_bit(lamp), .load_strobe(ld));
  vfdc_host_model host_u (.shift_clock_n(sck_n), .cs_n(cs_n), .serial_data_in(sdi));
  // count load pulses away from the edge that launches them
  always @(negedge clk) begin
    if (ld === 1'b1)
      n_loads <= n_loads + 1;
  end
  // 100 ns system clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // send one byte and step the reference model
  task automatic send(logic [7:0] b);
    host_u.put_bits(b, 8);
    m_loads++;
    if (m_st == 0) begin
      if (b[7] && b[6:4] <= 3'h4) begin
        m_op = b[6:4];
        m_st = 1;
      end
    end else if (m_st == 2 || m_op == 1) begin
      m_ram[m_addr] = b;
      m_addr = (m_addr + 1) % 16;
      m_st = 2;
    end else begin
      case (m_op)
        0: m_addr = b[3:0];
        2: m_duty = b[3:0];
        3: m_dig = b[3:0];
        default: m_lamp = b[0];
      endcase
      m_st = 0;
    end
  endtask
  // compare registers and every written digit
  task automatic compare();
    repeat (2) @(posedge clk);
    #1;
    check({4'h0, duty}, 8'(m_duty));
    check({4'h0, digits}, 8'(m_dig));
    check({3'h0, act}, (m_dig == 0) ? 8'h10 : 8'(m_dig));
    check({7'h0, lamp}, 8'(m_lamp));
    check(8'(n_loads), 8'(m_loads));
    for (int a = 0; a < 16; a++) begin
      if (m_ram[a] >= 0) begin
        @(posedge clk);
        rd_addr <= 4'(a);
        repeat (2) @(posedge clk);
        #1;
        check({cur, code}, 8'(m_ram[a]));
      end
    end
  endtask
  task automatic frame(logic [7:0] b[6], int n);
    host_u.frame_start();
    m_st = 0;
    for (int i = 0; i < n; i++) send(b[i]);
    host_u.frame_end();
    compare();
    $display("test frame of %0d bytes done", n);
  endtask
  // main sequence
  initial begin
    seed = 32'hab0c74fb;
    arst_n = 1'b0;
    rd_addr = 4'h0;
    cyc = 0;
    foreach (m_ram[i]) m_ram[i] = -1;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    compare();
    $display("test reset values done");
    for (int op = 0; op < 5; op++) begin
      frame('{8'h80 | 8'(op << 4) | 8'($random(seed) & 15), 8'($random(seed)), 8'h00, 8'h00, 8'h00, 8'h00},
        2);
    end
    frame('{8'h81, 8'h0f, 8'h90, 8'($random(seed)), 8'($random(seed)), 8'($random(seed))}, 6);
    frame('{8'h25, 8'hf3, 8'ha0, 8'h07, 8'h00, 8'h00}, 4);
    host_u.frame_start();
    host_u.put_bits(8'hff, 5);
    host_u.frame_end();
    compare();
    $display("test partial byte done");
    frame('{8'hb0, 8'h00, 8'hc0, 8'h01, 8'h00, 8'h00}, 4);
    print_verdict();
  end
endmodule
